// ---- verilog/mps_top.sv ----
// motor profile selector with apb register file
`timescale 1ns/1ns
module mps_top (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [4:0]            term_in,
    output mps_pkg::mps_curve_t        thermal_curve,
    output mps_pkg::mps_flux_t         flux_const_sel,
    output logic                       second_function_input,
    output logic                       second_motor_active,
    output logic                       tuning_allowed,
    output logic [7:0]                 low_speed_voltage_boost,
    output logic [7:0]                 dc_brake_voltage
);

    typedef struct packed {
        logic [5:0]          applied;
        logic [13:0]         second;
        logic [7:0]          visib;
        logic [7:0]          boost;
        logic [7:0]          dcb;
        logic [29:0]         tmap;
        logic                ctrl;
        logic                rejected;
        logic [4:0]          t1;
        logic [4:0]          t2;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
        mps_pkg::mps_curve_t curve;
        mps_pkg::mps_flux_t  flux;
        logic                sf;
        logic                m2;
        logic                tune;
    } mps_state_t;

    mps_state_t s_r;
    mps_state_t s_nxt;

    function automatic logic applied_ok(input logic [31:0] v);
        logic ok;
        ok = 1'b0;
        if (v[31:6] == 26'h0000000) begin
            case (v[5:0])
                mps_pkg::AM_0, mps_pkg::AM_1, mps_pkg::AM_3,
                mps_pkg::AM_13, mps_pkg::AM_23, mps_pkg::AM_40,
                mps_pkg::AM_43, mps_pkg::AM_50, mps_pkg::AM_53: ok = 1'b1;
                default: ok = 1'b0;
            endcase
        end
        return ok;
    endfunction

    function automatic logic second_ok(input logic [31:0] v);
        logic ok;
        ok = (v[31:14] == 18'h00000) &&
             (v[13:0] == mps_pkg::SM_STD || v[13:0] == mps_pkg::SM_CT ||
              v[13:0] == mps_pkg::SM_NONE);
        return ok;
    endfunction

    // constant-torque class for the boost and brake rewrite
    function automatic logic is_ct(input logic [5:0] v);
        logic ct;
        case (v)
            mps_pkg::AM_1, mps_pkg::AM_13, mps_pkg::AM_50, mps_pkg::AM_53: ct = 1'b1;
            default: ct = 1'b0;
        endcase
        return ct;
    endfunction

    function automatic mps_pkg::mps_curve_t curve_of(input logic [5:0] v);
        mps_pkg::mps_curve_t c;
        case (v)
            mps_pkg::AM_1, mps_pkg::AM_13: c = mps_pkg::CURVE_CT;
            mps_pkg::AM_40, mps_pkg::AM_43: c = mps_pkg::CURVE_HE;
            mps_pkg::AM_50, mps_pkg::AM_53: c = mps_pkg::CURVE_CT2;
            default: c = mps_pkg::CURVE_STD;
        endcase
        return c;
    endfunction

    always_comb begin
        logic                sf_now;
        logic                m2_now;
        logic                err;
        logic [31:0]         rd;
        logic [5:0]          wa;
        sf_now = 1'b0;
        m2_now = 1'b0;
        err    = 1'b0;
        rd     = 32'h00000000;
        wa     = pwdata[5:0];
        s_nxt  = s_r;

        // terminals are pins: second stage only is decoded
        s_nxt.t1 = term_in;
        s_nxt.t2 = s_r.t1;

        for (int i = 0; i < mps_pkg::NUM_TERM; i++) begin
            if (s_r.tmap[i*mps_pkg::TMAP_FW +: mps_pkg::TMAP_FW] == mps_pkg::SF_CODE && s_r.t2[i]) begin
                sf_now = 1'b1;
            end
        end
        m2_now = (s_r.second != mps_pkg::SM_NONE) && sf_now;

        // profile outputs
        if (m2_now) begin
            s_nxt.curve = (s_r.second == mps_pkg::SM_CT) ? mps_pkg::CURVE_CT : mps_pkg::CURVE_STD;
            s_nxt.flux  = mps_pkg::FLUX_NONE;
        end else begin
            s_nxt.curve = curve_of(s_r.applied);
            case (s_r.applied)
                mps_pkg::AM_23: s_nxt.flux = mps_pkg::FLUX_STD;
                mps_pkg::AM_43: s_nxt.flux = mps_pkg::FLUX_HE;
                mps_pkg::AM_53: s_nxt.flux = mps_pkg::FLUX_CT2;
                default:        s_nxt.flux = mps_pkg::FLUX_NONE;
            endcase
        end
        s_nxt.sf = sf_now;
        s_nxt.m2 = m2_now;
        case (s_r.applied)
            mps_pkg::AM_3, mps_pkg::AM_13, mps_pkg::AM_23,
            mps_pkg::AM_43, mps_pkg::AM_53: s_nxt.tune = 1'b1;
            default: s_nxt.tune = 1'b0;
        endcase

        // read data and error decision, taken in first access cycle
        case (paddr)
            mps_pkg::OFS_APPLIED: begin
                rd[5:0] = s_r.applied;
                err     = pwrite && (s_r.visib != 8'h00 || !applied_ok(pwdata));
            end
            mps_pkg::OFS_SECOND: begin
                rd[13:0] = s_r.second;
                err      = pwrite && (s_r.visib != 8'h00 || !second_ok(pwdata));
            end
            mps_pkg::OFS_VISIB:  rd[7:0]  = s_r.visib;
            mps_pkg::OFS_BOOST:  rd[7:0]  = s_r.boost;
            mps_pkg::OFS_DCB:    rd[7:0]  = s_r.dcb;
            mps_pkg::OFS_TMAP:   rd[29:0] = s_r.tmap;
            mps_pkg::OFS_CTRL:   rd[0]    = s_r.ctrl;
            mps_pkg::OFS_STATUS: begin
                rd[mps_pkg::ST_CURVE_LSB +: 2] = s_r.curve;
                rd[mps_pkg::ST_FLUX_LSB +: 2]  = s_r.flux;
                rd[mps_pkg::ST_REJ]            = s_r.rejected;
                rd[mps_pkg::ST_SF]             = s_r.sf;
                rd[mps_pkg::ST_M2]             = s_r.m2;
                rd[mps_pkg::ST_TUNE]           = s_r.tune;
                err                            = pwrite;
            end
            default: err = 1'b1;
        endcase

        // one wait state keeps every bus output on a flop
        s_nxt.pready = 1'b0;
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = err;
            s_nxt.prdata  = rd;
        end

        // writes commit on the edge that completes the transfer
        if (psel && penable && s_r.pready && pwrite) begin
            s_nxt.rejected = s_r.pslverr;
            if (!s_r.pslverr) begin
                case (paddr)
                    mps_pkg::OFS_APPLIED: begin
                        s_nxt.applied = wa;
                        // rewrite only on a real change, and only while ctrl is set
                        if (s_r.ctrl && wa != s_r.applied) begin
                            s_nxt.boost = is_ct(wa) ? mps_pkg::BOOST_CT : mps_pkg::BOOST_STD;
                            s_nxt.dcb   = is_ct(wa) ? mps_pkg::DCB_CT : mps_pkg::DCB_STD;
                        end
                    end
                    mps_pkg::OFS_SECOND: s_nxt.second = pwdata[13:0];
                    mps_pkg::OFS_VISIB:  s_nxt.visib  = pwdata[7:0];
                    mps_pkg::OFS_BOOST:  s_nxt.boost  = pwdata[7:0];
                    mps_pkg::OFS_DCB:    s_nxt.dcb    = pwdata[7:0];
                    mps_pkg::OFS_TMAP:   s_nxt.tmap   = pwdata[29:0];
                    mps_pkg::OFS_CTRL:   s_nxt.ctrl   = pwdata[0];
                    default: s_nxt.ctrl = s_r.ctrl;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_r          <= '0;
            s_r.applied  <= mps_pkg::APPLIED_RST;
            s_r.second   <= mps_pkg::SECOND_RST;
            s_r.visib    <= mps_pkg::VISIB_RST;
            s_r.boost    <= mps_pkg::BOOST_RST;
            s_r.dcb      <= mps_pkg::DCB_RST;
            s_r.tmap     <= mps_pkg::TMAP_RST;
            s_r.ctrl     <= mps_pkg::CTRL_RST;
            s_r.curve    <= mps_pkg::CURVE_STD;
            s_r.flux     <= mps_pkg::FLUX_NONE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata                  = s_r.prdata;
    assign pready                  = s_r.pready;
    assign pslverr                 = s_r.pslverr;
    assign thermal_curve           = s_r.curve;
    assign flux_const_sel          = s_r.flux;
    assign second_function_input   = s_r.sf;
    assign second_motor_active     = s_r.m2;
    assign tuning_allowed          = s_r.tune;
    assign low_speed_voltage_boost = s_r.boost;
    assign dc_brake_voltage        = s_r.dcb;

endmodule

// ---- verilog/mps_pkg.sv ----
// constants and types for the motor profile selector
package mps_pkg;

    localparam logic [7:0]  OFS_APPLIED   = 8'h00;
    localparam logic [7:0]  OFS_SECOND    = 8'h04;
    localparam logic [7:0]  OFS_VISIB     = 8'h08;
    localparam logic [7:0]  OFS_BOOST     = 8'h0C;
    localparam logic [7:0]  OFS_DCB       = 8'h10;
    localparam logic [7:0]  OFS_TMAP      = 8'h14;
    localparam logic [7:0]  OFS_CTRL      = 8'h18;
    localparam logic [7:0]  OFS_STATUS    = 8'h1C;

    localparam logic [5:0]  AM_0          = 6'h00;
    localparam logic [5:0]  AM_1          = 6'h01;
    localparam logic [5:0]  AM_3          = 6'h03;
    localparam logic [5:0]  AM_13         = 6'h0D;
    localparam logic [5:0]  AM_23         = 6'h17;
    localparam logic [5:0]  AM_40         = 6'h28;
    localparam logic [5:0]  AM_43         = 6'h2B;
    localparam logic [5:0]  AM_50         = 6'h32;
    localparam logic [5:0]  AM_53         = 6'h35;
    localparam logic [5:0]  APPLIED_RST   = 6'h00;

    localparam logic [13:0] SM_STD        = 14'h0000;
    localparam logic [13:0] SM_CT         = 14'h0001;
    localparam logic [13:0] SM_NONE       = 14'h270F;
    localparam logic [13:0] SECOND_RST    = 14'h270F;

    localparam logic [7:0]  VISIB_RST     = 8'h00;
    localparam logic [7:0]  BOOST_STD     = 8'h03;
    localparam logic [7:0]  BOOST_CT      = 8'h02;
    localparam logic [7:0]  DCB_STD       = 8'h04;
    localparam logic [7:0]  DCB_CT        = 8'h02;
    localparam logic [7:0]  BOOST_RST     = 8'h03;
    localparam logic [7:0]  DCB_RST       = 8'h04;

    localparam int          NUM_TERM      = 5;
    localparam int          TMAP_FW       = 6;
    localparam logic [5:0]  SF_CODE       = 6'h03;
    localparam logic [29:0] TMAP_RST      = 30'h00000000;
    localparam logic        CTRL_RST      = 1'b1;

    localparam int          ST_CURVE_LSB  = 0;
    localparam int          ST_FLUX_LSB   = 2;
    localparam int          ST_REJ        = 4;
    localparam int          ST_SF         = 5;
    localparam int          ST_M2         = 6;
    localparam int          ST_TUNE       = 7;

    typedef enum logic [1:0] {CURVE_STD, CURVE_CT, CURVE_HE, CURVE_CT2} mps_curve_t;
    typedef enum logic [1:0] {FLUX_NONE, FLUX_STD, FLUX_HE, FLUX_CT2} mps_flux_t;

endpackage

// ---- sim/mps_assertions.sv ----
// port-level checks for the motor profile selector
`timescale 1ns/1ns
module mps_assertions (
    input wire logic                clock,
    input wire logic                rst,
    input wire logic                pready,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire mps_pkg::mps_curve_t thermal_curve,
    input wire mps_pkg::mps_flux_t  flux_const_sel,
    input wire logic                second_function_input,
    input wire logic                second_motor_active,
    input wire logic                tuning_allowed,
    input wire logic [7:0]          low_speed_voltage_boost,
    input wire logic [7:0]          dc_brake_voltage
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    rst_vals_a: assert property ($fell(rst) |-> low_speed_voltage_boost == 8'h03 && thermal_curve == 2'h0)
        else $error("wrong output after reset");
    tune_curve_a: assert property (tuning_allowed && flux_const_sel == 2'h0 && !second_motor_active |-> thermal_curve < 2'h2)
        else $error("tuning motor without constants has wrong curve");
    flux_tuned_a: assert property (flux_const_sel != 2'h0 |-> tuning_allowed)
        else $error("motor constants loaded for non tuning value");
    flux_curve_a: assert property (flux_const_sel != 2'h0 |-> thermal_curve == (flux_const_sel == 2'h1 ? 2'h0 : flux_const_sel))
        else $error("motor constants and curve disagree");
    m2_curve_a: assert property (second_motor_active |-> thermal_curve < 2'h2 && flux_const_sel == 2'h0)
        else $error("second motor curve out of set");
    m2_sf_a: assert property (second_motor_active |-> second_function_input)
        else $error("second motor active without second function");
    boost_cause_a: assert property ($changed(low_speed_voltage_boost) |-> $past(pready && pwrite && (paddr == mps_pkg::OFS_APPLIED || paddr == mps_pkg::OFS_BOOST), 1))
        else $error("boost changed without cause");
    dcb_cause_a: assert property ($changed(dc_brake_voltage) |-> $past(pready && pwrite && (paddr == mps_pkg::OFS_APPLIED || paddr == mps_pkg::OFS_DCB), 1))
        else $error("brake voltage changed without cause");

    cover property (second_motor_active);
    cover property (flux_const_sel == 2'h2);
    cover property (second_function_input && !second_motor_active);
endmodule

bind mps_top mps_assertions mps_assertions_i (.*);

// ---- sim/mps_term_model.sv ----
// input terminal block: raises one pin when asked
`timescale 1ns/1ns
module mps_term_model (
    input  wire logic       clock,
    input  wire logic [2:0] pin,
    input  wire logic       level,
    output logic      [4:0] term_in
);
    // a switch closes on a clock edge, never mid-cycle
    always @(posedge clock)
        term_in <= 5'(level) << pin;
endmodule

// ---- sim/tb_motor_profile_select.sv ----
// self-checking bench for the motor profile selector
`timescale 1ns/1ns
module tb_motor_profile_select;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, second_function_input, second_motor_active, tuning_allowed;
    logic [4:0] term_in;
    logic [2:0] pin = 3'h0;
    logic level = 1'b0;
    mps_pkg::mps_curve_t thermal_curve;
    mps_pkg::mps_flux_t flux_const_sel;
    logic [7:0] low_speed_voltage_boost, dc_brake_voltage;
    int mismatches = 0;
    int n_tests = 0;

    mps_top mps_top_i (.*);
    mps_term_model mps_term_model_i (.*);

    initial forever #2 clock = ~clock;

    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", s, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        chk("wait", 32'h2, 32'(n));
        chk("pslverr", 32'(xe), 32'(pslverr));
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: the next setup must not reassign psel in this step
        @(posedge clock);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(1'b0, a, 32'h0, xe);
        chk("rdata", x, rd);
    endtask

    // outputs lag the register or terminal by a few edges
    task automatic outs(input logic [1:0] c, input logic [1:0] f, input logic [7:0] b, input logic [7:0] v);
        repeat (3) @(posedge clock);
        chk("curve", 32'(c), 32'(thermal_curve));
        chk("flux", 32'(f), 32'(flux_const_sel));
        chk("boost", 32'(b), 32'(low_speed_voltage_boost));
        chk("brake", 32'(v), 32'(dc_brake_voltage));
    endtask

    task automatic t_reset();
        rdc(mps_pkg::OFS_APPLIED, 32'h0, 1'b0);
        rdc(mps_pkg::OFS_SECOND, 32'h270F, 1'b0);
        outs(2'h0, 2'h0, 8'h03, 8'h04);
    endtask

    task automatic t_applied();
        logic [5:0] v[9] = '{6'h01, 6'h00, 6'h03, 6'h0D, 6'h17, 6'h28, 6'h2B, 6'h32, 6'h35};
        logic [1:0] c[9] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2, 2'h3, 2'h3};
        logic [1:0] f[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h0, 2'h3};
        logic ct[9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        logic tu[9] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, mps_pkg::OFS_APPLIED, 32'(v[i]), 1'b0);
            outs(c[i], f[i], ct[i] ? 8'h02 : 8'h03, ct[i] ? 8'h02 : 8'h04);
            chk("tune", 32'(tu[i]), 32'(tuning_allowed));
        end
    endtask

    task automatic t_reject();
        apb(1'b1, mps_pkg::OFS_APPLIED, 32'h02, 1'b1);
        rdc(mps_pkg::OFS_STATUS, 32'h9F, 1'b0);
        apb(1'b1, mps_pkg::OFS_SECOND, 32'h02, 1'b1);
        apb(1'b1, mps_pkg::OFS_VISIB, 32'h01, 1'b0);
        apb(1'b1, mps_pkg::OFS_APPLIED, 32'h00, 1'b1);
        apb(1'b1, mps_pkg::OFS_SECOND, 32'h01, 1'b1);
        apb(1'b1, mps_pkg::OFS_VISIB, 32'h00, 1'b0);
        rdc(mps_pkg::OFS_APPLIED, 32'h35, 1'b0);
        rdc(mps_pkg::OFS_SECOND, 32'h270F, 1'b0);
        rdc(8'h20, 32'h0, 1'b1);
        outs(2'h3, 2'h3, 8'h02, 8'h02);
    endtask

    task automatic t_second();
        apb(1'b1, mps_pkg::OFS_TMAP, 32'h3000, 1'b0);
        pin <= 3'h2;
        level <= 1'b1;
        repeat (2) @(posedge clock);
        outs(2'h3, 2'h3, 8'h02, 8'h02);
        chk("sf", 32'h1, 32'(second_function_input));
        apb(1'b1, mps_pkg::OFS_SECOND, 32'h1, 1'b0);
        outs(2'h1, 2'h0, 8'h02, 8'h02);
        chk("m2", 32'h1, 32'(second_motor_active));
        level <= 1'b0;
        repeat (2) @(posedge clock);
        outs(2'h3, 2'h3, 8'h02, 8'h02);
        apb(1'b1, mps_pkg::OFS_SECOND, 32'h0, 1'b0);
        level <= 1'b1;
        repeat (2) @(posedge clock);
        outs(2'h0, 2'h0, 8'h02, 8'h02);
    endtask

    // ctrl cleared keeps boost and brake; no rewrite without a real change
    task automatic t_rating();
        apb(1'b1, mps_pkg::OFS_CTRL, 32'h0, 1'b0);
        apb(1'b1, mps_pkg::OFS_BOOST, 32'h07, 1'b0);
        apb(1'b1, mps_pkg::OFS_APPLIED, 32'h00, 1'b0);
        rdc(mps_pkg::OFS_BOOST, 32'h07, 1'b0);
        rdc(mps_pkg::OFS_DCB, 32'h02, 1'b0);
        apb(1'b1, mps_pkg::OFS_CTRL, 32'h1, 1'b0);
        apb(1'b1, mps_pkg::OFS_APPLIED, 32'h00, 1'b0);
        rdc(mps_pkg::OFS_BOOST, 32'h07, 1'b0);
        apb(1'b1, mps_pkg::OFS_STATUS, 32'h0, 1'b1);
    endtask

    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_applied();
        t_reject();
        t_second();
        t_rating();
        end_of_test();
    end
endmodule
